/* pkg/cof_pkg.sv */
package cof_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int CAP_W = 16;
	localparam int MW_W = 3;
	localparam int UD_W = 7;
	localparam int LBA_W = 48;
	localparam int L28_W = 28;
	localparam int SEL_W = 3;

	// ----------------------------------------
	// Capability bit positions
	// ----------------------------------------
	localparam int CAP_HPA = 0;
	localparam int CAP_PUIS = 1;
	localparam int CAP_SEC = 2;
	localparam int CAP_SMART = 3;

	// ----------------------------------------
	// Command codes and factory defaults
	// ----------------------------------------
	localparam logic [7:0] OPCODE_DEF = 8'hF0;
	localparam logic [7:0] FEAT_FREEZE_DEF = 8'h01;
	localparam logic [7:0] FEAT_IDENT_DEF = 8'h02;
	localparam logic [7:0] FEAT_RESTORE_DEF = 8'h03;
	localparam logic [7:0] FEAT_SET_DEF = 8'h04;
	localparam logic [CAP_W-1:0] FACT_CAPS_DEF = 16'hFFFF;
	localparam logic [MW_W-1:0] FACT_MW_DEF = 3'h7;
	localparam logic [UD_W-1:0] FACT_UD_DEF = 7'h7F;
	localparam logic [LBA_W-1:0] FACT_MAX_DEF = 48'h000010000000;

	// ----------------------------------------
	// Capacity limits of 28-bit addressing
	// ----------------------------------------
	localparam logic [L28_W-1:0] LBA28_LIM = 28'hFFFFFFF;
	localparam logic [L28_W-1:0] NAT28_CLAMP = 28'hFFFFFFE;

	// ----------------------------------------
	// Overlay states
	// ----------------------------------------
	typedef enum logic [1:0] {
		cof_as_built_state = 2'b00,
		cof_frozen_state = 2'b01,
		cof_trimmed_state = 2'b10,
		cof_loading_state = 2'b11
	} cof_state_t;

	// Clip a 48-bit count to what 28-bit commands can see
	function automatic logic [L28_W-1:0] cof_clip28(input logic [LBA_W-1:0] v,
		input logic [L28_W-1:0] lim);
		if (v > {{(LBA_W-L28_W){1'b0}}, lim}) begin
			return lim;
		end
		return v[L28_W-1:0];
	endfunction : cof_clip28

endpackage : cof_pkg

/* pkg/cof_chk_if.sv */
`timescale 1ns/10ps
interface cof_chk_if;
	import cof_pkg::*;

	logic [CAP_W-1:0] req_caps;
	logic [MW_W-1:0] req_mw;
	logic [UD_W-1:0] req_ud;
	logic [LBA_W-1:0] req_max;
	logic [CAP_W-1:0] cur_caps;
	logic [MW_W-1:0] cur_mw;
	logic [UD_W-1:0] cur_ud;
	logic [SEL_W-1:0] mw_sel;
	logic mw_on;
	logic [SEL_W-1:0] ud_sel;
	logic ud_on;
	logic hpa_any;
	logic hpa_28;
	logic puis_jmp;
	logic sec_en;
	logic smart_en;
	logic [1:0] id_w7;
	logic [CAP_W-1:0] fact_caps;
	logic [LBA_W-1:0] fact_max;
	logic set_ok;
	logic restore_ok;

	modport fsm (
		output req_caps, req_mw, req_ud, req_max, cur_caps, cur_mw, cur_ud,
		output mw_sel, mw_on, ud_sel, ud_on, hpa_any, hpa_28, puis_jmp,
		output sec_en, smart_en, id_w7, fact_caps, fact_max,
		input set_ok, restore_ok
	);
	modport chk (
		input req_caps, req_mw, req_ud, req_max, cur_caps, cur_mw, cur_ud,
		input mw_sel, mw_on, ud_sel, ud_on, hpa_any, hpa_28, puis_jmp,
		input sec_en, smart_en, id_w7, fact_caps, fact_max,
		output set_ok, restore_ok
	);

endinterface : cof_chk_if

/* rtl/cof_set_check.sv */
`timescale 1ns/10ps
module cof_set_check (
	cof_chk_if.chk c // Request and device conditions
);
	import cof_pkg::*;

	// Modes at or below the selected one
	function automatic logic [UD_W-1:0] cof_low_mask(input logic [SEL_W-1:0] sel,
		input logic on);
		logic [UD_W-1:0] m;
		m = '0;
		for (int i = 0; i < UD_W; i++) begin
			m[i] = on && (i <= int'(sel));
		end
		return m;
	endfunction : cof_low_mask

	// ----------------------------------------
	// Validity of set and restore
	// ----------------------------------------
	logic [CAP_W-1:0] drop;
	logic [UD_W-1:0] mw_low;
	logic [MW_W-1:0] mw_mask;
	logic [UD_W-1:0] ud_mask;
	logic bad;

	always_comb begin
		drop = c.cur_caps & ~c.req_caps;
		// Mask is built at ultra width, multiword keeps only its low modes
		mw_low = cof_low_mask(c.mw_sel, c.mw_on);
		mw_mask = mw_low[MW_W-1:0];
		ud_mask = cof_low_mask(c.ud_sel, c.ud_on);
		bad = c.hpa_any;
		bad = bad | c.hpa_28;
		bad = bad | ((c.cur_mw & ~c.req_mw & mw_mask) != '0);
		bad = bad | ((c.cur_ud & ~c.req_ud & ud_mask) != '0);
		bad = bad | (drop[CAP_HPA] & c.hpa_any);
		bad = bad | (drop[CAP_PUIS] & c.puis_jmp);
		bad = bad | (drop[CAP_SEC] & c.sec_en);
		bad = bad | (drop[CAP_SMART] & (c.smart_en | (c.id_w7 != 2'h0)));
		// Only clearing is allowed, never adding or growing
		bad = bad | ((c.req_caps & ~c.fact_caps) != '0);
		bad = bad | (c.req_max == '0) | (c.req_max > c.fact_max);
		c.set_ok = !bad;
		c.restore_ok = !c.hpa_28;
	end

endmodule : cof_set_check

/* rtl/cof_fsm.sv */
`timescale 1ns/10ps
module cof_fsm #(
	parameter logic [7:0] OPCODE = cof_pkg::OPCODE_DEF,
	parameter logic [7:0] FEAT_FREEZE = cof_pkg::FEAT_FREEZE_DEF,
	parameter logic [7:0] FEAT_IDENT = cof_pkg::FEAT_IDENT_DEF,
	parameter logic [7:0] FEAT_RESTORE = cof_pkg::FEAT_RESTORE_DEF,
	parameter logic [7:0] FEAT_SET = cof_pkg::FEAT_SET_DEF,
	parameter logic [cof_pkg::CAP_W-1:0] FACT_CAPS = cof_pkg::FACT_CAPS_DEF,
	parameter logic [cof_pkg::MW_W-1:0] FACT_MW = cof_pkg::FACT_MW_DEF,
	parameter logic [cof_pkg::UD_W-1:0] FACT_UD = cof_pkg::FACT_UD_DEF,
	parameter logic [cof_pkg::LBA_W-1:0] FACT_MAX = cof_pkg::FACT_MAX_DEF
) (
	input logic clk, // 125 MHz clock
	input logic rst, // Hardware or software reset
	input logic por, // Power-on reset
	input logic cmd_valid, // Command strobe
	input logic [7:0] cmd_code, // Command opcode
	input logic [7:0] cmd_feat, // Features value
	input logic [cof_pkg::CAP_W-1:0] set_caps, // Requested capabilities
	input logic [cof_pkg::MW_W-1:0] set_mw, // Requested multiword modes
	input logic [cof_pkg::UD_W-1:0] set_ud, // Requested ultra modes
	input logic [cof_pkg::LBA_W-1:0] set_max, // Requested max LBA plus one
	input logic hpa_any, // Protected area exists
	input logic hpa_28, // Area made by 28-bit command
	input logic [cof_pkg::SEL_W-1:0] mw_sel, // Selected multiword mode
	input logic mw_on, // Multiword mode selected
	input logic [cof_pkg::SEL_W-1:0] ud_sel, // Selected ultra mode
	input logic ud_on, // Ultra mode selected
	input logic puis_jmp, // Standby power-up by jumper
	input logic sec_en, // Security enabled
	input logic smart_en, // SMART enabled
	input logic [1:0] id_w7, // Identify word 7 bits 2:1
	input logic nv_load, // Stored record valid
	input logic nv_trimmed, // Stored record is reduced
	input logic [cof_pkg::CAP_W-1:0] nv_caps, // Stored capabilities
	input logic [cof_pkg::MW_W-1:0] nv_mw, // Stored multiword modes
	input logic [cof_pkg::UD_W-1:0] nv_ud, // Stored ultra modes
	input logic [cof_pkg::LBA_W-1:0] nv_max, // Stored capacity
	output logic cmd_done, // Command completed
	output logic cmd_abort, // Completion is an abort
	output cof_pkg::cof_state_t ovl_state, // Overlay state
	output logic [cof_pkg::CAP_W-1:0] cap_en, // Offered capabilities
	output logic [cof_pkg::MW_W-1:0] mw_en, // Offered multiword modes
	output logic [cof_pkg::UD_W-1:0] ud_en, // Offered ultra modes
	output logic [cof_pkg::LBA_W-1:0] max_lba, // Words 100 to 103
	output logic [cof_pkg::L28_W-1:0] max_lba28, // Words 60 to 61
	output logic [cof_pkg::LBA_W-1:0] native_max48, // 48-bit native max
	output logic [cof_pkg::L28_W-1:0] native_max28, // 28-bit native max
	output logic id_full, // Overlay identify data valid
	output logic [cof_pkg::CAP_W-1:0] full_caps, // Full capability list
	output logic [cof_pkg::MW_W-1:0] full_mw, // Full multiword list
	output logic [cof_pkg::UD_W-1:0] full_ud, // Full ultra list
	output logic [cof_pkg::LBA_W-1:0] full_max, // Full capacity
	output logic nv_wr // Store current record
);
	import cof_pkg::*;

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		cof_state_t st;
		logic [CAP_W-1:0] caps;
		logic [MW_W-1:0] mw;
		logic [UD_W-1:0] ud;
		logic [LBA_W-1:0] maxl;
		logic [L28_W-1:0] w28;
		logic [LBA_W-1:0] nat48;
		logic [L28_W-1:0] nat28;
		logic [CAP_W-1:0] fcaps;
		logic [MW_W-1:0] fmw;
		logic [UD_W-1:0] fud;
		logic [LBA_W-1:0] fmax;
		logic done;
		logic abort;
		logic id_full;
		logic nv_wr;
	} cof_fsm_reg_t;

	cof_fsm_reg_t r;
	cof_fsm_reg_t next_r;
	logic take;

	cof_chk_if chk_bus ();

	// ----------------------------------------
	// Validity check of the request
	// ----------------------------------------
	assign chk_bus.req_caps = set_caps;
	assign chk_bus.req_mw = set_mw;
	assign chk_bus.req_ud = set_ud;
	assign chk_bus.req_max = set_max;
	assign chk_bus.cur_caps = r.caps;
	assign chk_bus.cur_mw = r.mw;
	assign chk_bus.cur_ud = r.ud;
	assign chk_bus.mw_sel = mw_sel;
	assign chk_bus.mw_on = mw_on;
	assign chk_bus.ud_sel = ud_sel;
	assign chk_bus.ud_on = ud_on;
	assign chk_bus.hpa_any = hpa_any;
	assign chk_bus.hpa_28 = hpa_28;
	assign chk_bus.puis_jmp = puis_jmp;
	assign chk_bus.sec_en = sec_en;
	assign chk_bus.smart_en = smart_en;
	assign chk_bus.id_w7 = id_w7;
	assign chk_bus.fact_caps = FACT_CAPS;
	assign chk_bus.fact_max = FACT_MAX;

	cof_set_check u_check (
		.c(chk_bus.chk)
	);

	// Commands are blind while either reset is held
	assign take = cmd_valid && (cmd_code == OPCODE) && !rst && !por;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.abort = 1'b0;
		next_r.id_full = 1'b0;
		next_r.nv_wr = 1'b0;

		// Stored record decides the first state after power-up
		if (r.st == cof_loading_state && nv_load) begin
			if (nv_trimmed) begin
				next_r.st = cof_trimmed_state;
				next_r.caps = nv_caps & FACT_CAPS;
				next_r.mw = nv_mw & FACT_MW;
				next_r.ud = nv_ud & FACT_UD;
				next_r.maxl = (nv_max > FACT_MAX) ? FACT_MAX : nv_max;
			end else begin
				next_r.st = cof_as_built_state;
			end
		end

		if (take) begin
			next_r.done = 1'b1;
			unique case (r.st)
				// No record yet, so nothing may change
				cof_loading_state: begin
					next_r.abort = 1'b1;
				end
				// Locked until the next power cycle
				cof_frozen_state: begin
					next_r.abort = 1'b1;
				end
				cof_as_built_state, cof_trimmed_state: begin
					if (cmd_feat == FEAT_FREEZE) begin
						next_r.st = cof_frozen_state;
					end else if (cmd_feat == FEAT_IDENT) begin
						next_r.id_full = 1'b1;
					end else if (cmd_feat == FEAT_SET) begin
						if (r.st == cof_as_built_state && chk_bus.set_ok) begin
							// Same as factory still counts as trimmed
							next_r.st = cof_trimmed_state;
							next_r.caps = set_caps;
							next_r.mw = set_mw;
							next_r.ud = set_ud;
							next_r.maxl = set_max;
							next_r.nv_wr = 1'b1;
						end else begin
							next_r.abort = 1'b1;
						end
					end else if (cmd_feat == FEAT_RESTORE) begin
						if (r.st == cof_trimmed_state && chk_bus.restore_ok) begin
							next_r.st = cof_as_built_state;
							next_r.caps = FACT_CAPS;
							next_r.mw = FACT_MW;
							next_r.ud = FACT_UD;
							next_r.maxl = FACT_MAX;
							next_r.nv_wr = 1'b1;
						end else begin
							next_r.abort = 1'b1;
						end
					end else begin
						next_r.abort = 1'b1;
					end
				end
			endcase
		end

		// Reported and native capacities track the live maximum
		next_r.w28 = cof_clip28(next_r.maxl, LBA28_LIM);
		next_r.nat48 = next_r.maxl - 48'h000000000001;
		next_r.nat28 = cof_clip28(next_r.nat48, NAT28_CLAMP);

		// Power cycle: freeze cleared, factory view until loaded
		if (por) begin
			next_r = '0;
			next_r.st = cof_loading_state;
			next_r.caps = FACT_CAPS;
			next_r.mw = FACT_MW;
			next_r.ud = FACT_UD;
			next_r.maxl = FACT_MAX;
			next_r.w28 = cof_clip28(FACT_MAX, LBA28_LIM);
			next_r.nat48 = FACT_MAX - 48'h000000000001;
			next_r.nat28 = cof_clip28(FACT_MAX - 48'h000000000001, NAT28_CLAMP);
			next_r.fcaps = FACT_CAPS;
			next_r.fmw = FACT_MW;
			next_r.fud = FACT_UD;
			next_r.fmax = FACT_MAX;
		end
	end

	// ----------------------------------------
	// Register
	// ----------------------------------------
	// Plain reset never touches the record, so a freeze survives it
	always_ff @(posedge clk) begin
		r <= next_r;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cmd_done = r.done;
	assign cmd_abort = r.abort;
	assign ovl_state = r.st;
	assign cap_en = r.caps;
	assign mw_en = r.mw;
	assign ud_en = r.ud;
	// Normal identify words show only the live, possibly reduced, view
	assign max_lba = r.maxl;
	assign max_lba28 = r.w28;
	assign native_max48 = r.nat48;
	assign native_max28 = r.nat28;
	assign id_full = r.id_full;
	// Full list is kept apart and only flagged by overlay identify
	assign full_caps = r.fcaps;
	assign full_mw = r.fmw;
	assign full_ud = r.fud;
	assign full_max = r.fmax;
	assign nv_wr = r.nv_wr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || por);

	chk_frozen_sticks: assert property (
		r.st == cof_frozen_state |=> r.st == cof_frozen_state)
		else $error("frozen state left without power cycle");

	chk_frozen_aborts: assert property (
		take && r.st == cof_frozen_state |=> r.done && r.abort)
		else $error("command in frozen state not aborted");

	chk_freeze_ok: assert property (
		take && cmd_feat == FEAT_FREEZE &&
		(r.st == cof_as_built_state || r.st == cof_trimmed_state)
		|=> r.done && !r.abort && r.st == cof_frozen_state)
		else $error("freeze did not succeed");

	chk_set_enters: assert property (
		take && cmd_feat == FEAT_SET && r.st == cof_as_built_state &&
		chk_bus.set_ok |=> !r.abort && r.st == cof_trimmed_state &&
		r.maxl == $past(set_max) && r.nv_wr &&
		r.nat48 == $past(set_max) - 48'h000000000001)
		else $error("valid set not applied");

	chk_built_restore: assert property (
		take && cmd_feat == FEAT_RESTORE && r.st == cof_as_built_state
		|=> r.abort && r.st == cof_as_built_state)
		else $error("restore in as-built not aborted");

	chk_trim_set: assert property (
		take && cmd_feat == FEAT_SET && r.st == cof_trimmed_state
		|=> r.abort && r.st == cof_trimmed_state && $stable(r.caps))
		else $error("set in trimmed state not aborted");

	chk_set_hpa: assert property (
		take && cmd_feat == FEAT_SET && hpa_any |=> r.abort && $stable(r.maxl))
		else $error("set accepted with protected area");

	chk_restore_hpa: assert property (
		take && cmd_feat == FEAT_RESTORE && hpa_28 |=> r.abort)
		else $error("restore accepted with 28-bit area");

	chk_native_max: assert property (
		r.nat48 == r.maxl - 48'h000000000001 && r.nat28 <= NAT28_CLAMP)
		else $error("native max not tied to capacity");

	chk_restore_full: assert property (
		take && cmd_feat == FEAT_RESTORE && r.st == cof_trimmed_state &&
		!hpa_28 |=> r.st == cof_as_built_state && r.caps == r.fcaps &&
		r.maxl == r.fmax)
		else $error("restore did not return full view");

	chk_only_clears: assert property (
		r.st != cof_loading_state |-> (r.caps & ~r.fcaps) == '0 && r.maxl <= r.fmax)
		else $error("view exceeds factory configuration");

	chk_identify_ok: assert property (
		take && cmd_feat == FEAT_IDENT && r.st != cof_frozen_state &&
		r.st != cof_loading_state |=> r.id_full && !r.abort && $stable(r.st))
		else $error("overlay identify failed");

	chk_load_aborts: assert property (
		take && r.st == cof_loading_state |=> r.abort && r.st == cof_loading_state)
		else $error("command in loading state not aborted");

	chk_load_state: assert property (
		r.st == cof_loading_state && nv_load |=>
		r.st == ($past(nv_trimmed) ? cof_trimmed_state : cof_as_built_state))
		else $error("stored record not applied at power-up");

	chk_set_refused: assert property (
		take && cmd_feat == FEAT_SET && r.st == cof_as_built_state && !chk_bus.set_ok
		|=> r.abort && r.st == cof_as_built_state && $stable(r.caps) && $stable(r.maxl))
		else $error("invalid set not refused");

	chk_restore_stores: assert property (
		take && cmd_feat == FEAT_RESTORE && r.st == cof_trimmed_state &&
		chk_bus.restore_ok |=> !r.abort && r.nv_wr)
		else $error("restore not stored");

	chk_foreign_code: assert property (
		cmd_valid && cmd_code != OPCODE |=> !r.done)
		else $error("foreign opcode completed");

endmodule : cof_fsm

/* test/cof_host.sv */
`timescale 1ns/10ps
// --------------
// Host adapter
// --------------
module cof_host (
	input wire logic clk, // Bench clock
	output logic cmd_valid, // Command strobe
	output logic [7:0] cmd_code, // Opcode
	output logic [7:0] cmd_feat, // Features value
	output logic [cof_pkg::CAP_W-1:0] set_caps, // Set capabilities
	output logic [cof_pkg::MW_W-1:0] set_mw, // Set multiword modes
	output logic [cof_pkg::UD_W-1:0] set_ud, // Set ultra modes
	output logic [cof_pkg::LBA_W-1:0] set_max // Set capacity
);
	import cof_pkg::*;

	// Quiet bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_feat = 8'h00;
		set_caps = '0;
		set_mw = '0;
		set_ud = '0;
		set_max = '0;
	end

	// One opcode for all subcommands, Features selects
	// Released lines flip so a stale payload never looks valid
	task automatic send(input logic [7:0] code, input logic [7:0] feat,
		input logic [CAP_W-1:0] caps, input logic [MW_W-1:0] mw, input logic [UD_W-1:0] ud,
		input logic [LBA_W-1:0] mx);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_feat <= feat;
		set_caps <= caps;
		set_mw <= mw;
		set_ud <= ud;
		set_max <= mx;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code <= ~code;
		cmd_feat <= ~feat;
		set_caps <= ~caps;
		set_mw <= ~mw;
		set_ud <= ~ud;
		set_max <= ~mx;
	endtask : send
endmodule : cof_host

/* test/test_config_overlay_fsm.sv */
`timescale 1ns/10ps
module test_config_overlay_fsm;
	import cof_pkg::*;

	// --------------
	// Signals
	// --------------
	logic clk, rst, por, cmd_valid, hpa_any, hpa_28, mw_on, ud_on, puis_jmp, sec_en, smart_en;
	logic nv_load, nv_trimmed, cmd_done, cmd_abort, id_full, nv_wr, ms_t;
	logic [7:0] cmd_code, cmd_feat;
	logic [CAP_W-1:0] set_caps, nv_caps, cap_en, full_caps, m_caps, ms_c, p_caps;
	logic [MW_W-1:0] set_mw, nv_mw, mw_en, full_mw, m_mw, ms_m, p_mw;
	logic [UD_W-1:0] set_ud, nv_ud, ud_en, full_ud, m_ud, ms_u, p_ud;
	logic [LBA_W-1:0] set_max, nv_max, max_lba, native_max48, full_max, m_max, ms_x, p_max;
	logic [L28_W-1:0] max_lba28, native_max28;
	logic [SEL_W-1:0] mw_sel, ud_sel;
	logic [1:0] id_w7, m_st;
	cof_state_t ovl_state;
	int n_mismatch, tests_run, r;
	logic [2:0] exp_q[$];

	cof_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_feat(cmd_feat),
		.set_caps(set_caps), .set_mw(set_mw), .set_ud(set_ud), .set_max(set_max));

	cof_fsm i_cof_fsm (.clk(clk), .rst(rst), .por(por), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_feat(cmd_feat), .set_caps(set_caps), .set_mw(set_mw), .set_ud(set_ud),
		.set_max(set_max), .hpa_any(hpa_any), .hpa_28(hpa_28), .mw_sel(mw_sel), .mw_on(mw_on),
		.ud_sel(ud_sel), .ud_on(ud_on), .puis_jmp(puis_jmp), .sec_en(sec_en), .smart_en(smart_en),
		.id_w7(id_w7), .nv_load(nv_load), .nv_trimmed(nv_trimmed), .nv_caps(nv_caps),
		.nv_mw(nv_mw), .nv_ud(nv_ud), .nv_max(nv_max), .cmd_done(cmd_done),
		.cmd_abort(cmd_abort), .ovl_state(ovl_state), .cap_en(cap_en), .mw_en(mw_en),
		.ud_en(ud_en), .max_lba(max_lba), .max_lba28(max_lba28), .native_max48(native_max48),
		.native_max28(native_max28), .id_full(id_full), .full_caps(full_caps),
		.full_mw(full_mw), .full_ud(full_ud), .full_max(full_max), .nv_wr(nv_wr));

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Nonvolatile memory: keeps what the block stores, returns it at power-up
	always @(posedge clk) begin
		if (nv_wr === 1'b1) begin
			nv_trimmed <= ovl_state == cof_trimmed_state;
			nv_caps <= cap_en;
			nv_mw <= mw_en;
			nv_ud <= ud_en;
			nv_max <= max_lba;
		end
	end

	// --------------
	// Checking
	// --------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// Offered configuration and the capacity views derived from it
	task automatic chk_state();
		logic [LBA_W-1:0] n;
		n = m_max - 48'h000000000001;
		chk(ovl_state, m_st);
		chk(cap_en, m_caps);
		chk(mw_en, m_mw);
		chk(ud_en, m_ud);
		chk(max_lba, m_max);
		chk(max_lba28, (m_max > 48'h00000FFFFFFF) ? 28'hFFFFFFF : m_max[27:0]);
		chk(native_max48, n);
		chk(native_max28, (n > 48'h00000FFFFFFE) ? 28'hFFFFFFE : n[27:0]);
	endtask : chk_state

	// Power cycle, then hand back the stored record
	task automatic power_cycle();
		@(posedge clk);
		por <= 1'b1;
		repeat (3) @(posedge clk);
		por <= 1'b0;
		// Before the record arrives every command aborts on the factory view
		m_st = 2'h3;
		{m_caps, m_mw, m_ud, m_max} = {FACT_CAPS_DEF, FACT_MW_DEF, FACT_UD_DEF, FACT_MAX_DEF};
		do_cmd(OPCODE_DEF, FEAT_SET_DEF, 1'b0);
		@(posedge clk);
		nv_load <= 1'b1;
		@(posedge clk);
		nv_load <= 1'b0;
		#1;
		m_st = ms_t ? 2'h2 : 2'h0;
		{m_caps, m_mw, m_ud, m_max} = {ms_c, ms_m, ms_u, ms_x};
		chk_state();
	endtask : power_cycle

	// Random conditions and payload, one command, reference answer
	task automatic do_cmd(input logic [7:0] code, input logic [7:0] feat, input logic hold);
		logic ab, idf, ok, take;
		logic [2:0] e;
		int q;
		q = $urandom % 8;
		@(posedge clk);
		rst <= hold;
		hpa_any <= q < 2;
		hpa_28 <= q == 0;
		mw_on <= ($urandom % 4) == 0;
		mw_sel <= SEL_W'($urandom % 3);
		ud_on <= ($urandom % 4) == 0;
		ud_sel <= SEL_W'($urandom % 7);
		puis_jmp <= ($urandom % 4) == 0;
		sec_en <= ($urandom % 4) == 0;
		smart_en <= ($urandom % 4) == 0;
		id_w7 <= (($urandom % 6) == 0) ? 2'($urandom) : 2'h0;
		p_caps = CAP_W'($urandom | $urandom);
		p_mw = MW_W'($urandom | $urandom);
		p_ud = UD_W'($urandom | $urandom);
		case ($urandom % 6)
			0: p_max = 48'h000000000000;
			1: p_max = FACT_MAX_DEF + 48'h000000000001;
			2: p_max = FACT_MAX_DEF;
			default: p_max = LBA_W'($urandom % 32'h10000000) + 48'h000000000001;
		endcase
		u_host.send(code, feat, p_caps, p_mw, p_ud, p_max);
		rst <= 1'b0;
		#1;
		take = !hold && code == OPCODE_DEF;
		ok = !hpa_any && p_max != 48'h0 && p_max <= FACT_MAX_DEF;
		for (int k = 0; k < UD_W; k++) begin
			if (!p_ud[k] && m_ud[k] && ud_on && k <= ud_sel) ok = 1'b0;
			if (k < MW_W && !p_mw[k] && m_mw[k] && mw_on && k <= mw_sel) ok = 1'b0;
		end
		if ((puis_jmp && !p_caps[CAP_PUIS]) || (sec_en && !p_caps[CAP_SEC])) ok = 1'b0;
		if ((smart_en || id_w7 != 2'h0) && !p_caps[CAP_SMART]) ok = 1'b0;
		ab = 1'b1;
		idf = 1'b0;
		// Frozen and loading fall through: everything aborts and the state stays
		if (take && !m_st[0]) begin
			if (feat == FEAT_FREEZE_DEF) begin
				ab = 1'b0;
				m_st = 2'h1;
			end else if (feat == FEAT_IDENT_DEF) begin
				ab = 1'b0;
				idf = 1'b1;
			end else if (feat == FEAT_RESTORE_DEF && m_st == 2'h2 && !hpa_28) begin
				ab = 1'b0;
				m_st = 2'h0;
				{m_caps, m_mw, m_ud, m_max} = {FACT_CAPS_DEF, FACT_MW_DEF, FACT_UD_DEF, FACT_MAX_DEF};
			end else if (feat == FEAT_SET_DEF && m_st == 2'h0 && ok) begin
				ab = 1'b0;
				m_st = 2'h2;
				{m_caps, m_mw, m_ud, m_max} = {p_caps, p_mw, p_ud, p_max};
			end
			if (!ab && (feat == FEAT_SET_DEF || feat == FEAT_RESTORE_DEF)) begin
				{ms_t, ms_c, ms_m, ms_u, ms_x} = {m_st == 2'h2, m_caps, m_mw, m_ud, m_max};
			end
		end
		// Expected completion passes through the model's queue
		exp_q.push_back({take, ab, idf});
		e = exp_q.pop_front();
		chk(cmd_done, e[2]);
		if (e[2]) begin
			chk(cmd_abort, e[1]);
			chk(id_full, e[0]);
		end
		chk(nv_wr, take && !ab && (feat == FEAT_SET_DEF || feat == FEAT_RESTORE_DEF));
		if (idf) chk({full_caps, full_mw, full_ud}, {FACT_CAPS_DEF, FACT_MW_DEF, FACT_UD_DEF});
		if (idf) chk(full_max, FACT_MAX_DEF);
		chk_state();
	endtask : do_cmd

	// --------------
	// Main sequence
	// --------------
	initial begin
		void'($urandom(56));
		{rst, por, nv_load, nv_trimmed, ms_t, hpa_any, hpa_28} = 7'h60;
		{mw_on, ud_on, puis_jmp, sec_en, smart_en, mw_sel, ud_sel, id_w7} = '0;
		{nv_caps, nv_mw, nv_ud, nv_max} = {FACT_CAPS_DEF, FACT_MW_DEF, FACT_UD_DEF, FACT_MAX_DEF};
		{ms_c, ms_m, ms_u, ms_x} = {FACT_CAPS_DEF, FACT_MW_DEF, FACT_UD_DEF, FACT_MAX_DEF};
		n_mismatch = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		power_cycle();
		for (int i = 0; i < 400; i++) begin
			r = $urandom % 16;
			do_cmd((($urandom % 20) == 0) ? 8'hEF : OPCODE_DEF, (r == 0) ? FEAT_FREEZE_DEF :
				(r == 1) ? 8'h05 : (r < 6) ? FEAT_IDENT_DEF : (r < 10) ? FEAT_RESTORE_DEF :
				FEAT_SET_DEF, ($urandom % 20) == 0);
			// Once frozen: every code aborts, reset keeps it, only power clears it
			if (m_st == 2'h1) begin
				for (int f = 1; f < 6; f++) do_cmd(OPCODE_DEF, 8'(f), 1'b0);
				@(posedge clk);
				rst <= 1'b1;
				repeat (2) @(posedge clk);
				rst <= 1'b0;
				#1;
				chk_state();
				power_cycle();
			end
		end
		final_report();
	end

	// Watchdog, well past the expected few thousand cycles
	initial begin
		#400000;
		n_mismatch++;
		final_report();
	end
endmodule : test_config_overlay_fsm
